//--- hw/mpm_regs.svh
`ifndef MPM_REGS_SVH
`define MPM_REGS_SVH

// Register byte offsets
`define MPM_HARDWARE_CONFIGURATION_OFS 8'h00
`define MPM_GPIO_CTRL_OFS 8'h04
`define MPM_PIN_STAT_OFS 8'h08
`define MPM_RX_COUNT_OFS 8'h0C

// hardware_configuration fields
`define MPM_CFG_EXT_PHY_BIT 0
`define MPM_CFG_VIS_EN_BIT 1
`define MPM_CFG_WAKE_MODE_BIT 2
`define MPM_CFG_XOVER_BIT 3
`define MPM_CFG_WIDTH 4
`define MPM_CFG_RESET 4'h0

// gpio control fields, three GPIOs each: 0 = col, 1 = mdio, 2 = crs
`define MPM_GPIO_OE_LSB 0
`define MPM_GPIO_OD_LSB 4
`define MPM_GPIO_VAL_LSB 8
`define MPM_GPIO_COUNT 3
`define MPM_GPIO_RESET 3'h0

// Status layout
`define MPM_STAT_GPIO_LSB 0
`define MPM_STAT_TXCLK_BIT 4
`define MPM_STAT_WMS_BIT 5
`define MPM_STAT_XOVER_BIT 6

`define MPM_COUNT_WIDTH 16
`define MPM_SYNC_STAGES 2

`endif

//--- hw/mpm_pkg.sv
package mpm_pkg;

   // Function currently steering one multiplexed pin
   typedef enum logic [1:0] {
      mpm_fn_ext = 2'b00,
      mpm_fn_visible = 2'b01,
      mpm_fn_gpio = 2'b10,
      mpm_fn_off = 2'b11
   } mpm_func_t;

   // Role of the collision and management data pins when no MII use claims them
   typedef enum logic [1:0] {
      mpm_aux_none = 2'b00,
      mpm_aux_wake = 2'b01,
      mpm_aux_gpio = 2'b10,
      mpm_aux_rsvd = 2'b11
   } mpm_aux_t;

endpackage

//--- hw/mpm_sync.sv
`timescale 1ns/1ps
`include "mpm_regs.svh"

module mpm_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_reg;

   if (WIDTH < 1) begin : g_chk
      $error("mpm_sync WIDTH must be at least 1");
   end

   // First stage is read by the second stage only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end

endmodule

//--- hw/mpm_link_rx.sv
`timescale 1ns/1ps
`include "mpm_regs.svh"

module mpm_link_rx (
   input wire logic link_clk,
   input wire logic presetn,
   input wire logic ext_mode,
   input wire logic rxdv_pin,
   input wire logic rxer_pin,
   output logic rxdv_q,
   output logic rxer_q,
   output logic frame_tgl,
   output logic err_tgl
);

   logic [1:0] rst_sync_reg;
   logic [1:0] mode_sync_reg;
   logic link_rst_n;
   logic mode;
   logic err_seen_reg;
   logic frame_start;
   logic frame_err;

   assign link_rst_n = rst_sync_reg[1];
   assign mode = mode_sync_reg[1];
   // Pins are synchronous to this clock, so one stage of sampling suffices
   assign frame_start = rxdv_pin & ~rxdv_q & mode;
   assign frame_err = rxer_pin & rxdv_pin & ~err_seen_reg & mode;

   // Reset released on this clock; asserted at once
   always_ff @(posedge link_clk or negedge presetn) begin
      if (!presetn) begin
         rst_sync_reg <= 2'h0;
         mode_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
         mode_sync_reg <= {mode_sync_reg[0], ext_mode};
      end
   end

   // Clock may stop between frames; events leave as toggles
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rxdv_q <= 1'b0;
         rxer_q <= 1'b0;
         frame_tgl <= 1'b0;
         err_tgl <= 1'b0;
         err_seen_reg <= 1'b0;
      end else begin
         rxdv_q <= rxdv_pin & mode;
         rxer_q <= rxer_pin & mode;
         frame_tgl <= frame_tgl ^ frame_start;
         err_tgl <= err_tgl ^ frame_err;
         err_seen_reg <= rxdv_pin & (err_seen_reg | rxer_pin);
      end
   end

endmodule

//--- hw/mpm_pin_mux.sv
`timescale 1ns/1ps
`include "mpm_regs.svh"

module mpm_pin_mux #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mii_rxclk,
   input wire logic int_rxer,
   input wire logic int_txen,
   input wire logic int_rxdv,
   input wire logic int_rxclk,
   input wire logic int_txclk,
   input wire logic int_crs,
   input wire logic int_col,
   input wire logic int_mdio,
   input wire logic int_mdc,
   input wire logic mac_txen,
   input wire logic mac_mdc,
   input wire logic mac_mdio_o,
   input wire logic mac_mdio_oe,
   output logic ext_rxdv,
   output logic ext_rxer,
   output logic ext_crs,
   output logic ext_col,
   output logic ext_mdio_i,
   input wire logic pme_wake,
   output logic wake_mode_select_input,
   input wire logic crossover_req,
   output logic pair_swap,
   input wire logic rxer_pin_i,
   output logic rxer_pin_o,
   output logic rxer_pin_oe,
   input wire logic txen_pin_i,
   output logic txen_pin_o,
   output logic txen_pin_oe,
   input wire logic rxdv_pin_i,
   output logic rxdv_pin_o,
   output logic rxdv_pin_oe,
   output logic rxclk_pin_o,
   output logic rxclk_pin_oe,
   input wire logic txclk_pin_i,
   output logic txclk_pin_o,
   output logic txclk_pin_oe,
   input wire logic crs_pin_i,
   output logic crs_pin_o,
   output logic crs_pin_oe,
   input wire logic col_pin_i,
   output logic col_pin_o,
   output logic col_pin_oe,
   input wire logic mdio_pin_i,
   output logic mdio_pin_o,
   output logic mdio_pin_oe,
   output logic mdc_pin_o,
   output logic mdc_pin_oe
);

   if (ADDR_W < 8) begin : g_chk
      $error("mpm_pin_mux ADDR_W must be at least 8");
   end

   localparam int GN = `MPM_GPIO_COUNT;
   localparam int CW = `MPM_COUNT_WIDTH;

   if (GN != 3) begin : g_gn_chk
      $error("mpm_pin_mux serves exactly three shared GPIO pins");
   end

   if (CW != 16) begin : g_cw_chk
      $error("mpm_pin_mux counts must be 16 bits to share one read word");
   end

   // GPIO drive: {oe, o}; open drain only pulls low
   function automatic logic [1:0] gpio_drive(input logic oe, input logic od, input logic val);
      gpio_drive = {oe & (~od | ~val), val};
   endfunction

   // Pick {oe, o} for a pin from its function
   function automatic logic [1:0] pin_pick(input mpm_pkg::mpm_func_t fn,
                                           input logic [1:0] ext_drv,
                                           input logic vis_val,
                                           input logic [1:0] aux_drv);
      case (fn)
         mpm_pkg::mpm_fn_ext: pin_pick = ext_drv;
         mpm_pkg::mpm_fn_visible: pin_pick = {1'b1, vis_val};
         mpm_pkg::mpm_fn_gpio: pin_pick = aux_drv;
         default: pin_pick = 2'b00;
      endcase
   endfunction

   // Configuration and counters
   logic [`MPM_CFG_WIDTH-1:0] cfg_reg;
   logic [`MPM_CFG_WIDTH-1:0] cfg_next;
   logic [GN-1:0] gpio_oe_reg;
   logic [GN-1:0] gpio_od_reg;
   logic [GN-1:0] gpio_val_reg;
   logic [CW-1:0] frame_cnt_reg;
   logic [CW-1:0] err_cnt_reg;
   logic [CW-1:0] frame_cnt_next;
   logic [CW-1:0] err_cnt_next;
   logic [31:0] prdata_next;
   logic pslverr_next;
   logic frame_tgl_reg;
   logic err_tgl_reg;

   // APB decode
   wire [7:0] offs = paddr[7:0];
   // Upper address bits must be clear, else registers would alias
   wire upper_zero = (paddr >> 8) == '0;
   wire hit_cfg = upper_zero & (offs == `MPM_HARDWARE_CONFIGURATION_OFS);
   wire hit_gpio = upper_zero & (offs == `MPM_GPIO_CTRL_OFS);
   wire hit_stat = upper_zero & (offs == `MPM_PIN_STAT_OFS);
   wire hit_cnt = upper_zero & (offs == `MPM_RX_COUNT_OFS);
   wire mapped = hit_cfg | hit_gpio | hit_stat | hit_cnt;
   wire setup = psel & ~penable;
   wire wr_en = psel & penable & pready & pwrite & mapped;
   wire wr_cfg = wr_en & hit_cfg & pstrb[0];
   wire wr_gpio0 = wr_en & hit_gpio & pstrb[0];
   wire wr_gpio1 = wr_en & hit_gpio & pstrb[1];
   wire wr_cnt = wr_en & hit_cnt;

   // Selection settings, all registered so the mux never sees a bus glitch
   wire ext_mode = cfg_reg[`MPM_CFG_EXT_PHY_BIT];
   wire vis_en = cfg_reg[`MPM_CFG_VIS_EN_BIT];
   wire wake_mode = cfg_reg[`MPM_CFG_WAKE_MODE_BIT];
   wire xover_en = cfg_reg[`MPM_CFG_XOVER_BIT];

   // Synchronised pin inputs: {mdio, txclk, col, crs}
   logic [3:0] pin_sync;
   wire crs_s = pin_sync[0];
   wire col_s = pin_sync[1];
   wire txclk_s = pin_sync[2];
   wire mdio_s = pin_sync[3];

   mpm_sync #(
      .WIDTH(4)
   ) u_pin_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({mdio_pin_i, txclk_pin_i, col_pin_i, crs_pin_i}),
      .q(pin_sync)
   );

   // Link clock domain: receive-side monitor
   logic rxdv_link;
   logic rxer_link;
   logic frame_tgl;
   logic err_tgl;
   logic [1:0] tgl_sync;

   mpm_link_rx u_link (
      .link_clk(mii_rxclk),
      .presetn(presetn),
      .ext_mode(ext_mode),
      .rxdv_pin(rxdv_pin_i),
      .rxer_pin(rxer_pin_i),
      .rxdv_q(rxdv_link),
      .rxer_q(rxer_link),
      .frame_tgl(frame_tgl),
      .err_tgl(err_tgl)
   );

   mpm_sync #(
      .WIDTH(2)
   ) u_tgl_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({err_tgl, frame_tgl}),
      .q(tgl_sync)
   );

   // Toggles, not pulses: a pulse is lost when the link clock stops
   wire frame_evt = tgl_sync[0] ^ frame_tgl_reg;
   wire err_evt = tgl_sync[1] ^ err_tgl_reg;

   // Per-pin function select
   wire int_vis = ~ext_mode & vis_en;
   wire int_wake = ~ext_mode & ~vis_en & wake_mode;
   wire int_gpio = ~ext_mode & ~vis_en;
   mpm_pkg::mpm_func_t fn_mii;
   mpm_pkg::mpm_func_t fn_gp;
   assign fn_mii = ext_mode ? mpm_pkg::mpm_fn_ext :
                   int_vis ? mpm_pkg::mpm_fn_visible : mpm_pkg::mpm_fn_off;
   assign fn_gp = ext_mode ? mpm_pkg::mpm_fn_ext :
                  int_vis ? mpm_pkg::mpm_fn_visible :
                  int_gpio ? mpm_pkg::mpm_fn_gpio : mpm_pkg::mpm_fn_off;

   mpm_pkg::mpm_aux_t aux_col;
   mpm_pkg::mpm_aux_t aux_mdio;
   assign aux_col = int_wake ? mpm_pkg::mpm_aux_wake : mpm_pkg::mpm_aux_gpio;
   assign aux_mdio = int_wake ? mpm_pkg::mpm_aux_wake : mpm_pkg::mpm_aux_gpio;

   wire [1:0] gp_col = gpio_drive(gpio_oe_reg[0], gpio_od_reg[0], gpio_val_reg[0]);
   wire [1:0] gp_mdio = gpio_drive(gpio_oe_reg[1], gpio_od_reg[1], gpio_val_reg[1]);
   wire [1:0] gp_crs = gpio_drive(gpio_oe_reg[2], gpio_od_reg[2], gpio_val_reg[2]);
   // Wake drives the collision pin push-pull with the wake level
   wire [1:0] aux_col_drv = (aux_col == mpm_pkg::mpm_aux_wake) ?
                            {1'b1, pme_wake} : gp_col;
   // Wake mode turns the management data pin into an input
   wire [1:0] aux_mdio_drv = (aux_mdio == mpm_pkg::mpm_aux_wake) ?
                             2'b00 : gp_mdio;

   wire [1:0] rxer_next = pin_pick(fn_mii, 2'b00, int_rxer, 2'b00);
   wire [1:0] txen_next = pin_pick(fn_mii, {1'b1, mac_txen}, int_txen, 2'b00);
   wire [1:0] rxdv_next = pin_pick(fn_mii, 2'b00, int_rxdv, 2'b00);
   wire [1:0] rxclk_next = pin_pick(fn_mii, 2'b00, int_rxclk, 2'b00);
   wire [1:0] txclk_next = pin_pick(fn_mii, 2'b00, int_txclk, 2'b00);
   wire [1:0] crs_next = pin_pick(fn_gp, 2'b00, int_crs, gp_crs);
   wire [1:0] col_next = pin_pick(fn_gp, 2'b00, int_col, aux_col_drv);
   wire [1:0] mdio_next = pin_pick(fn_gp, {mac_mdio_oe, mac_mdio_o}, int_mdio,
                                   aux_mdio_drv);
   wire [1:0] mdc_next = pin_pick(fn_mii, {1'b1, mac_mdc}, int_mdc, 2'b00);

   // Configuration write
   assign cfg_next = wr_cfg ? pwdata[`MPM_CFG_WIDTH-1:0] : cfg_reg;

   // Counters: an event in the clearing cycle still counts
   assign frame_cnt_next = (wr_cnt ? '0 : frame_cnt_reg) + CW'(frame_evt);
   assign err_cnt_next = (wr_cnt ? '0 : err_cnt_reg) + CW'(err_evt);

   // Read data, captured in the setup cycle
   wire [31:0] rd_cfg = {{(32-`MPM_CFG_WIDTH){1'b0}}, cfg_reg};
   wire [31:0] rd_gpio = {20'h00000, 1'b0, gpio_val_reg, 1'b0, gpio_od_reg,
                          1'b0, gpio_oe_reg};
   wire [31:0] rd_stat = {25'h0000000, pair_swap, wake_mode_select_input, txclk_s,
                          1'b0, mdio_s, col_s, crs_s};
   wire [31:0] rd_cnt = {err_cnt_reg, frame_cnt_reg};
   assign prdata_next = hit_cfg ? rd_cfg :
                        hit_gpio ? rd_gpio :
                        hit_stat ? rd_stat :
                        hit_cnt ? rd_cnt : 32'h00000000;
   assign pslverr_next = ~mapped;

   // Bus slave: answer in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         prdata <= setup ? prdata_next : 32'h00000000;
         pslverr <= setup & pslverr_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= `MPM_CFG_RESET;
         gpio_oe_reg <= `MPM_GPIO_RESET;
         gpio_od_reg <= `MPM_GPIO_RESET;
      end else begin
         cfg_reg <= cfg_next;
         if (wr_gpio0) begin
            gpio_oe_reg <= pwdata[`MPM_GPIO_OE_LSB +: GN];
            gpio_od_reg <= pwdata[`MPM_GPIO_OD_LSB +: GN];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gpio_val_reg <= `MPM_GPIO_RESET;
         frame_cnt_reg <= '0;
         err_cnt_reg <= '0;
         frame_tgl_reg <= 1'b0;
         err_tgl_reg <= 1'b0;
      end else begin
         if (wr_gpio1) begin
            gpio_val_reg <= pwdata[`MPM_GPIO_VAL_LSB +: GN];
         end
         frame_cnt_reg <= frame_cnt_next;
         err_cnt_reg <= err_cnt_next;
         frame_tgl_reg <= tgl_sync[0];
         err_tgl_reg <= tgl_sync[1];
      end
   end

   // Pin drivers, registered so direction changes only on a clock edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {rxer_pin_oe, rxer_pin_o} <= 2'h0;
         {txen_pin_oe, txen_pin_o} <= 2'h0;
         {rxdv_pin_oe, rxdv_pin_o} <= 2'h0;
         {rxclk_pin_oe, rxclk_pin_o} <= 2'h0;
         {txclk_pin_oe, txclk_pin_o} <= 2'h0;
      end else begin
         {rxer_pin_oe, rxer_pin_o} <= rxer_next;
         {txen_pin_oe, txen_pin_o} <= txen_next;
         {rxdv_pin_oe, rxdv_pin_o} <= rxdv_next;
         {rxclk_pin_oe, rxclk_pin_o} <= rxclk_next;
         {txclk_pin_oe, txclk_pin_o} <= txclk_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {crs_pin_oe, crs_pin_o} <= 2'h0;
         {col_pin_oe, col_pin_o} <= 2'h0;
         {mdio_pin_oe, mdio_pin_o} <= 2'h0;
         {mdc_pin_oe, mdc_pin_o} <= 2'h0;
      end else begin
         {crs_pin_oe, crs_pin_o} <= crs_next;
         {col_pin_oe, col_pin_o} <= col_next;
         {mdio_pin_oe, mdio_pin_o} <= mdio_next;
         {mdc_pin_oe, mdc_pin_o} <= mdc_next;
      end
   end

   // Toward the MAC and wake logic; blocked outside their modes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_crs <= 1'b0;
         ext_col <= 1'b0;
         ext_mdio_i <= 1'b0;
         wake_mode_select_input <= 1'b0;
         pair_swap <= 1'b0;
      end else begin
         ext_crs <= ext_mode & crs_s;
         ext_col <= ext_mode & col_s;
         ext_mdio_i <= ext_mode & mdio_s;
         wake_mode_select_input <= int_wake & mdio_s;
         // Analog pair swap only makes sense with the internal PHY
         pair_swap <= ~ext_mode & xover_en & crossover_req;
      end
   end

   // Receive qualifiers stay in the link clock domain for the MAC
   assign ext_rxdv = rxdv_link;
   assign ext_rxer = rxer_link;

endmodule

//--- bench/mpm_pin_mux_checker.sv
`timescale 1ns/1ps
module mpm_pin_mux_checker #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic mac_txen,
   input wire logic mac_mdc,
   input wire logic mac_mdio_o,
   input wire logic mac_mdio_oe,
   input wire logic int_col,
   input wire logic int_rxer,
   input wire logic pme_wake,
   input wire logic crossover_req,
   input wire logic col_pin_i,
   input wire logic mdio_pin_i,
   input wire logic ext_col,
   input wire logic wake_mode_select_input,
   input wire logic pair_swap,
   input wire logic txen_pin_o,
   input wire logic txen_pin_oe,
   input wire logic rxer_pin_o,
   input wire logic rxer_pin_oe,
   input wire logic rxdv_pin_oe,
   input wire logic rxclk_pin_oe,
   input wire logic txclk_pin_oe,
   input wire logic crs_pin_oe,
   input wire logic col_pin_o,
   input wire logic col_pin_oe,
   input wire logic mdio_pin_o,
   input wire logic mdio_pin_oe,
   input wire logic mdc_pin_o,
   input wire logic mdc_pin_oe
);
   // Shadow of the mode bits, aged twice so pins have settled
   logic [3:0] c0, c1, c2;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {c0, c1, c2} <= 12'h000;
      end else begin
         if (psel && penable && pready && pwrite && paddr == 0 && pstrb[0]) begin
            c0 <= pwdata[3:0];
         end
         c1 <= c0;
         c2 <= c1;
      end
   end
   wire st = c0 == c1 && c1 == c2;
   wire ex = st && c1[0];
   wire vi = st && !c1[0] && c1[1];
   wire wk = st && !c1[0] && !c1[1] && c1[2];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence col_calm;
      (st && $stable(col_pin_i)) [*5];
   endsequence
   sequence mdio_calm;
      (st && $stable(mdio_pin_i)) [*5];
   endsequence
   chk_txen_driven: assert property (ex |-> txen_pin_oe && txen_pin_o == $past(mac_txen))
      else $error("txen pin not following mac");
   chk_mdc_driven: assert property (ex |-> mdc_pin_oe && mdc_pin_o == $past(mac_mdc))
      else $error("mdc pin not following mac");
   chk_mdio_two_way: assert property (ex |-> mdio_pin_oe == $past(mac_mdio_oe)
      && (!mdio_pin_oe || mdio_pin_o == $past(mac_mdio_o))) else $error("mdio pin wrong");
   chk_ext_inputs: assert property (ex |-> !(rxer_pin_oe || rxdv_pin_oe || rxclk_pin_oe
      || txclk_pin_oe || crs_pin_oe || col_pin_oe)) else $error("input pin driven");
   chk_vis_copy: assert property (vi |-> col_pin_oe && col_pin_o == $past(int_col)
      && rxer_pin_oe && rxer_pin_o == $past(int_rxer)) else $error("visible copy wrong");
   chk_wake_drive: assert property (wk |-> col_pin_oe && col_pin_o == $past(pme_wake))
      else $error("wake level not on col pin");
   chk_pair_swap: assert property (st |-> pair_swap == (!c1[0] && c1[3] && $past(crossover_req)))
      else $error("pair swap wrong");
   chk_col_sync: assert property (col_calm |-> ext_col == (c1[0] && col_pin_i))
      else $error("collision input wrong");
   chk_wake_sel: assert property (mdio_calm |-> wake_mode_select_input == (wk && mdio_pin_i))
      else $error("wake select input wrong");
endmodule

bind mpm_pin_mux mpm_pin_mux_checker #(.ADDR_W(ADDR_W)) chk (.*);

//--- bench/mpm_phy_model.sv
`timescale 1ns/1ps
module mpm_phy_model (
   input wire logic ext,
   input wire logic dut_mdio_oe,
   output logic rxclk,
   output logic rxdv,
   output logic rxer,
   output logic crs,
   output logic col,
   output logic txclk,
   output logic mdio,
   output logic mdio_oe
);
   initial begin
      {rxclk, rxdv, rxer, crs, col, mdio} = 6'h00;
   end
   // Clocks stand still between frames, like a quiet link
   assign txclk = ~rxclk;
   assign mdio_oe = ext && !dut_mdio_oe;
   always @(posedge rxclk) mdio <= !mdio;
   task automatic clocks(input int n);
      repeat (n) begin
         #24 rxclk = 1'b1;
         #24 rxclk = 1'b0;
      end
   endtask
   task automatic levels(input logic c, input logic k);
      crs <= c;
      col <= k;
   endtask
   // Data moves after the falling edge, held across the rising one
   task automatic frame(input int len, input logic err);
      for (int i = 0; i < len; i++) begin
         rxdv = 1'b1;
         rxer = err && i == 1;
         clocks(1);
      end
      rxdv = 1'b0;
      rxer = 1'b0;
      clocks(3);
   endtask
   // Receive qualifiers held at fixed levels over two clocks
   task automatic hold(input logic dv, input logic er);
      rxdv = dv;
      rxer = er;
      clocks(2);
   endtask
endmodule

//--- bench/test_mii_pin_function_mux.sv
`timescale 1ns/1ps
module test_mii_pin_function_mux;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, em = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, q;
   logic [3:0] pstrb = 4'hF;
   logic int_rxer = 0, int_txen = 0, int_rxdv = 0, int_rxclk = 0, int_txclk = 0;
   logic int_crs = 0, int_col = 0, int_mdio = 0, int_mdc = 0, pme_wake = 0, crossover_req = 0;
   logic mac_txen = 0, mac_mdc = 0, mac_mdio_o = 0, mac_mdio_oe = 0, e;
   logic [2:0] toe = 0, tv = 0;
   logic [8:0] pats [4] = '{9'h155, 9'h0AA, 9'h1FF, 9'h000};
   wire [31:0] prdata;
   wire pready, pslverr, ext_rxdv, ext_rxer, ext_crs, ext_col, ext_mdio_i;
   wire wake_mode_select_input, pair_swap, mii_rxclk, rxer_pin_i, txen_pin_i, rxdv_pin_i;
   wire txclk_pin_i, crs_pin_i, col_pin_i, mdio_pin_i, rxer_pin_o, rxer_pin_oe;
   wire txen_pin_o, txen_pin_oe, rxdv_pin_o, rxdv_pin_oe, rxclk_pin_o, rxclk_pin_oe;
   wire txclk_pin_o, txclk_pin_oe, crs_pin_o, crs_pin_oe, col_pin_o, col_pin_oe;
   wire mdio_pin_o, mdio_pin_oe, mdc_pin_o, mdc_pin_oe;
   wire p_rxclk, p_rxdv, p_rxer, p_crs, p_col, p_txclk, p_mdio, p_mdio_oe;
   int fails = 0, num_checks = 0;
   mpm_pin_mux #(.ADDR_W(8)) DUT (.*);
   mpm_phy_model phy (.ext(em), .dut_mdio_oe(mdio_pin_oe), .rxclk(p_rxclk), .rxdv(p_rxdv),
      .rxer(p_rxer), .crs(p_crs), .col(p_col), .txclk(p_txclk), .mdio(p_mdio), .mdio_oe(p_mdio_oe));
   // Board wiring: txclk, crs, col and mdio pulled up in internal mode, the PHY drives them in external mode
   assign mii_rxclk = rxclk_pin_oe ? rxclk_pin_o : p_rxclk;
   assign rxer_pin_i = rxer_pin_oe ? rxer_pin_o : p_rxer;
   assign rxdv_pin_i = rxdv_pin_oe ? rxdv_pin_o : p_rxdv;
   assign txen_pin_i = txen_pin_oe ? txen_pin_o : 1'b0;
   assign txclk_pin_i = txclk_pin_oe ? txclk_pin_o : em ? p_txclk : 1'b1;
   assign crs_pin_i = crs_pin_oe ? crs_pin_o : em ? p_crs : toe[2] ? tv[2] : 1'b1;
   assign col_pin_i = col_pin_oe ? col_pin_o : em ? p_col : toe[0] ? tv[0] : 1'b1;
   assign mdio_pin_i = mdio_pin_oe ? mdio_pin_o : p_mdio_oe ? p_mdio : toe[1] ? tv[1] : !em;
   initial forever #2.5 pclk = ~pclk;
   task automatic give_verdict;
      if (fails == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic ck(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         $display("mismatch at %0t: no pready", $time);
         give_verdict();
      end else begin
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      ck(q, x);
   endtask
   task automatic settle(input int k);
      repeat (k) @(posedge pclk);
   endtask
   task automatic t_regs;
      rdc(8'h00, 32'h0);
      rdc(8'h04, 32'h0);
      apb(1'b1, 8'h10, 32'hF);
      ck(e, 1'b1);
      pstrb <= 4'h2;
      apb(1'b1, 8'h00, 32'hF);
      pstrb <= 4'hF;
      rdc(8'h00, 32'h0);
   endtask
   task automatic t_ext;
      apb(1'b1, 8'h00, 32'h1);
      em <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         {mac_mdio_oe, mac_mdio_o, mac_mdc, mac_txen} <= i[3:0];
         settle(5);
         ck({txen_pin_oe, txen_pin_o}, {1'b1, i[0]});
         ck({mdc_pin_oe, mdc_pin_o}, {1'b1, i[1]});
         ck(mdio_pin_oe, i[3]);
         ck(mdio_pin_i ^ ext_mdio_i, 1'b0);
         ck({rxer_pin_oe, rxdv_pin_oe, rxclk_pin_oe, txclk_pin_oe}, 4'h0);
      end
      for (int j = 0; j < 2; j++) begin
         phy.levels(j[0], !j[0]);
         settle(5);
         ck({crs_pin_oe, col_pin_oe, ext_crs, ext_col}, {2'b00, j[0], !j[0]});
      end
   endtask
   task automatic t_frames;
      phy.clocks(3);
      apb(1'b1, 8'h0C, 32'h0);
      phy.frame(4, 1'b0);
      phy.frame(5, 1'b1);
      settle(8);
      rdc(8'h0C, 32'h0001_0002);
      phy.hold(1'b1, 1'b1);
      ck({ext_rxdv, ext_rxer}, 2'b11);
      phy.hold(1'b0, 1'b0);
      ck({ext_rxdv, ext_rxer}, 2'b00);
      apb(1'b1, 8'h00, 32'h0);
      em <= 1'b0;
      phy.clocks(3);
      phy.hold(1'b1, 1'b1);
      ck({ext_rxdv, ext_rxer}, 2'b00);
      phy.frame(4, 1'b1);
      settle(8);
      rdc(8'h0C, 32'h0002_0003);
      apb(1'b1, 8'h0C, 32'h0);
      rdc(8'h0C, 32'h0);
   endtask
   task automatic t_vis;
      apb(1'b1, 8'h00, 32'h2);
      foreach (pats[i]) begin
         {int_mdc, int_mdio, int_col, int_crs, int_txclk, int_rxclk, int_rxdv, int_txen,
            int_rxer} <= pats[i];
         settle(3);
         ck({mdc_pin_o, mdio_pin_o, col_pin_o, crs_pin_o, txclk_pin_o, rxclk_pin_o, rxdv_pin_o,
            txen_pin_o, rxer_pin_o}, pats[i]);
         ck({mdc_pin_oe, mdio_pin_oe, col_pin_oe, crs_pin_oe, txclk_pin_oe, rxclk_pin_oe,
            rxdv_pin_oe, txen_pin_oe, rxer_pin_oe}, 9'h1FF);
      end
   endtask
   task automatic t_gpio;
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h04, 32'h0000_0123);
      settle(3);
      ck({col_pin_oe, col_pin_o, mdio_pin_oe, mdio_pin_o}, 4'hE);
      apb(1'b1, 8'h04, 32'h0000_0323);
      toe <= 3'b100;
      tv <= 3'b100;
      settle(5);
      ck({mdio_pin_oe, mdio_pin_i}, 2'b01);
      rdc(8'h08, 32'h0000_0017);
      tv <= 3'b000;
      settle(5);
      rdc(8'h08, 32'h0000_0016);
      apb(1'b1, 8'h04, 32'h0);
   endtask
   task automatic t_wake;
      apb(1'b1, 8'h00, 32'h4);
      toe <= 3'b010;
      for (int i = 0; i < 2; i++) begin
         pme_wake <= i[0];
         tv <= {1'b0, !i[0], 1'b0};
         settle(6);
         ck({col_pin_oe, col_pin_o}, {1'b1, i[0]});
         ck({mdio_pin_oe, wake_mode_select_input}, {1'b0, !i[0]});
      end
      toe <= 3'b000;
   endtask
   task automatic t_xover;
      logic [3:0] cf [3] = '{4'h8, 4'h9, 4'h0};
      crossover_req <= 1'b1;
      foreach (cf[i]) begin
         apb(1'b1, 8'h00, {28'h0, cf[i]});
         em <= cf[i][0];
         settle(3);
         ck(pair_swap, cf[i] == 4'h8);
      end
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      phy.clocks(3);
      t_regs();
      t_ext();
      t_frames();
      t_vis();
      t_gpio();
      t_wake();
      t_xover();
      give_verdict();
   end
endmodule
